// ===== rtl/drc_defines.vh
// Constants for the refresh controller: register map, fields, reset values.
// Assumes inclusion by bare name from rtl/ design files.
`ifndef DRC_DEFINES_VH
`define DRC_DEFINES_VH
// ==========================================
// Register map (byte addresses on APB)
`define DRC_ADDR_W 8
// Control sits at word index 8'h36; its byte address is four times that
`define DRC_CTRL_IDX 8'h36
`define DRC_CTRL_ADDR 8'hD8
`define DRC_STAT_ADDR 8'h38
`define DRC_RADDR_ADDR 8'h3C
// ==========================================
// Control register fields
`define DRC_ON_BIT 7
`define DRC_WAIT_BIT 6
`define DRC_SEL_HI 1
`define DRC_SEL_LO 0
`define DRC_CTRL_RESET 8'hC0
`define DRC_CTRL_MASK 8'hC3
// ==========================================
// Interval counts in clock states
`define DRC_INT_0 8'h0A
`define DRC_INT_1 8'h14
`define DRC_INT_2 8'h28
`define DRC_INT_3 8'h50
`define DRC_CNT_W 8
// ==========================================
// Refresh cycle lengths in clocks
`define DRC_LEN_SHORT 2'h2
`define DRC_LEN_LONG 2'h3
`endif

// ===== rtl/drc_timer.v
// Free-running refresh interval timer.
// Assumes a single clock; interval select comes from the same domain.
`include "drc_defines.vh"
module drc_timer #(
    parameter CNT_W = `DRC_CNT_W
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Control
    input wire [1:0] sel,
    // Request
    output reg tick
);
    reg [CNT_W-1:0] count_reg;
    wire [CNT_W-1:0] limit;

    assign limit = (sel == 2'h0) ? `DRC_INT_0 :
                   (sel == 2'h1) ? `DRC_INT_1 :
                   (sel == 2'h2) ? `DRC_INT_2 : `DRC_INT_3; // RL4

    // Keeps running regardless of bus grant or sleep
    always @(posedge clk) begin
        if (srst) begin
            count_reg <= {CNT_W{1'b0}};
            tick <= 1'b0;
        end else if (count_reg >= limit - 1'b1) begin
            count_reg <= {CNT_W{1'b0}}; // RL15
            tick <= 1'b1; // RL8
        end else begin
            count_reg <= count_reg + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule // drc_timer

// ===== rtl/drc_refresh.v
// DRAM refresh controller with APB register access.
// Assumes CPU status inputs (grant, sleep, wait, machine-cycle end) are
// synchronous to CLOCK; they need no synchroniser.
//
// Summary of operation
// RL1: Refresh cycles are inserted only while the enable bit is set.
// RL2: Refresh cycles last two clocks, or three when the extra-wait bit is set.
// RL3: Reset sets both the enable bit and the extra-wait bit.
// RL4: The interval field selects 10, 20, 40 or 80 clock states between refreshes.
// RL5: Reset clears the interval field to zero.
// RL6: After reset refreshes come every 10 clocks and last 3 clocks.
// RL7: No refresh is inserted in reset, bus release, sleep or wait states.
// RL8: The interval timer keeps running while the bus is released.
// RL9: After bus regain the first refresh follows the next timer request.
// RL10: A request during sleep is latched, and a later one replaces it.
// RL11: A latched request runs at the end of the first machine cycle after sleep.
// RL12: Afterwards refresh timing follows only the timer.
// RL13: The refresh address advances by one per performed refresh cycle.
// RL14: Each refresh bus cycle shows the previous refresh address plus one.
// RL15: The timer counts clock states, requests at the interval and restarts at zero.
//
// Our own choice: register access over APB.
`include "drc_defines.vh"
module drc_refresh #(
    parameter RADDR_W = 8
) (
    // Clock and reset
    input wire CLOCK,
    input wire SRST,
    // APB slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [31:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // CPU status
    input wire BUS_GRANTED,
    input wire SLEEP_MODE,
    input wire WAIT_STATE,
    input wire MCYCLE_END,
    // Refresh bus cycle
    output reg REFRESH_ACTIVE,
    output reg REFRESH_WAIT_STATE,
    output reg [RADDR_W-1:0] REFRESH_ADDR
);
    // ==========================================
    // States
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_EXTRA = 3'b100;

    reg [7:0] ctrl_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg pend_reg;
    reg sleep_req_reg;
    reg sleep_d_reg;
    reg wake_reg;
    reg [1:0] phase_reg;
    reg [RADDR_W-1:0] addr_reg;
    wire tick;
    wire refresh_on;
    wire blocked;
    wire start;
    wire done;

    function addr_hit;
        input [31:0] a;
        input [7:0] r;
        begin
            addr_hit = (a[`DRC_ADDR_W-1:0] == r) && (a[31:`DRC_ADDR_W] == 24'h00_0000);
        end
    endfunction

    // ==========================================
    // Timer
    drc_timer #(
        .CNT_W(`DRC_CNT_W)
    ) u_timer (
        .clk(CLOCK),
        .srst(SRST),
        .sel(ctrl_reg[`DRC_SEL_HI:`DRC_SEL_LO]),
        .tick(tick)
    );

    assign refresh_on = ctrl_reg[`DRC_ON_BIT];
    assign blocked = BUS_GRANTED | SLEEP_MODE | WAIT_STATE; // RL7
    // Post-sleep refresh waits for machine-cycle end; normal ones take next slot
    assign start = (state_reg == ST_IDLE) && refresh_on && !blocked &&
                   (wake_reg ? MCYCLE_END : pend_reg); // RL1 RL9 RL11
    assign done = (state_reg == ST_RUN && phase_reg == 2'h1 && !ctrl_reg[`DRC_WAIT_BIT]) ||
                  (state_reg == ST_EXTRA); // RL2

    // ==========================================
    // Request bookkeeping
    always @(posedge CLOCK) begin
        if (SRST) begin
            pend_reg <= 1'b0;
            sleep_req_reg <= 1'b0;
            sleep_d_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            sleep_d_reg <= SLEEP_MODE;
            // Cleared first so a fresh wake request in the same cycle wins
            if (start && wake_reg)
                wake_reg <= 1'b0; // RL12
            // Only one request is ever held; missed ones are dropped
            if (SLEEP_MODE) begin
                if (tick)
                    sleep_req_reg <= 1'b1; // RL10
            end else if (sleep_d_reg && sleep_req_reg) begin
                wake_reg <= 1'b1;
                sleep_req_reg <= 1'b0;
            end
            // Requests under bus release are dropped, not served at handover
            if (tick && !SLEEP_MODE && !BUS_GRANTED)
                pend_reg <= 1'b1;
            else if (start || BUS_GRANTED)
                pend_reg <= 1'b0; // RL9
        end
    end

    // ==========================================
    // Refresh cycle sequencer
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start)
                    state_next = ST_RUN;
            end
            ST_RUN: begin
                if (done)
                    state_next = ST_IDLE;
                else if (phase_reg == 2'h1)
                    state_next = ST_EXTRA; // RL2
            end
            ST_EXTRA: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge CLOCK) begin
        if (SRST) begin
            state_reg <= ST_IDLE;
            phase_reg <= 2'h0;
            addr_reg <= {RADDR_W{1'b0}};
            REFRESH_ACTIVE <= 1'b0;
            REFRESH_WAIT_STATE <= 1'b0;
            REFRESH_ADDR <= {RADDR_W{1'b0}};
        end else begin
            state_reg <= state_next;
            // Restart at zero on entry so a cycle spans two or three clocks
            phase_reg <= (state_reg == ST_RUN && state_next == ST_RUN) ? phase_reg + 2'h1 : 2'h0;
            REFRESH_ACTIVE <= (state_next != ST_IDLE);
            REFRESH_WAIT_STATE <= (state_next == ST_EXTRA);
            if (start)
                REFRESH_ADDR <= addr_reg; // RL14
            if (done)
                addr_reg <= addr_reg + 1'b1; // RL13
        end
    end

    // ==========================================
    // APB slave, zero wait states
    always @(posedge CLOCK) begin
        if (SRST) begin
            ctrl_reg <= `DRC_CTRL_RESET; // RL3 RL5 RL6
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            if (PSEL && !PENABLE) begin
                PRDATA <= 32'h0000_0000;
                if (addr_hit(PADDR, `DRC_CTRL_ADDR))
                    PRDATA <= {24'h00_0000, ctrl_reg};
                else if (addr_hit(PADDR, `DRC_STAT_ADDR))
                    PRDATA <= {28'h000_0000, wake_reg | sleep_req_reg, pend_reg,
                               REFRESH_WAIT_STATE, REFRESH_ACTIVE};
                else if (addr_hit(PADDR, `DRC_RADDR_ADDR))
                    PRDATA <= {{(32-RADDR_W){1'b0}}, addr_reg};
                else
                    PSLVERR <= 1'b1;
            end
            if (PSEL && PENABLE && PREADY && PWRITE &&
                addr_hit(PADDR, `DRC_CTRL_ADDR))
                ctrl_reg <= PWDATA[7:0] & `DRC_CTRL_MASK;
        end
    end
endmodule // drc_refresh

// ===== bench/drc_props_properties.sv
// Port checker for the refresh controller.
// Assumes one clock; bound from the bench top.
module drc_props #(parameter RADDR_W = 8) (
    // Clock, reset, bus
    input wire CLOCK, SRST, PSEL, PENABLE, PREADY,
    // Status and refresh
    input wire BUS_GRANTED, SLEEP_MODE, WAIT_STATE, REFRESH_ACTIVE, REFRESH_WAIT_STATE,
    input wire [RADDR_W-1:0] REFRESH_ADDR
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    // Last start address, so skips show across long gaps
    reg [RADDR_W-1:0] last_reg;
    reg seen_reg;
    always @(posedge CLOCK) begin
        if (SRST)
            seen_reg <= 1'b0;
        else if ($rose(REFRESH_ACTIVE)) begin
            seen_reg <= 1'b1;
            last_reg <= REFRESH_ADDR;
        end
    end
    apb_ready_a: assert property (PSEL && PENABLE && !$past(PENABLE) |-> PREADY)
        else $error("ready late");
    ref_len_a: assert property ($rose(REFRESH_ACTIVE) |-> ##1 REFRESH_ACTIVE ##1
        (!REFRESH_ACTIVE or (REFRESH_WAIT_STATE ##1 !REFRESH_ACTIVE))) else $error("length");
    wait_pos_a: assert property (REFRESH_WAIT_STATE |->
        REFRESH_ACTIVE && $past(REFRESH_ACTIVE, 2)) else $error("wait clock");
    no_block_a: assert property ($rose(REFRESH_ACTIVE) |-> !$past(BUS_GRANTED) &&
        !$past(SLEEP_MODE) && !$past(WAIT_STATE)) else $error("blocked start");
    addr_inc_a: assert property ($rose(REFRESH_ACTIVE) && seen_reg |->
        REFRESH_ADDR == last_reg + 1'b1) else $error("address step");
    addr_hold_a: assert property (REFRESH_ACTIVE && $past(REFRESH_ACTIVE) |->
        $stable(REFRESH_ADDR)) else $error("address moved");
    rst_quiet_a: assert property (disable iff (1'b0) SRST |=> !REFRESH_ACTIVE && !PREADY)
        else $error("busy in reset");
    first_ref_a: assert property ($fell(SRST) |-> ##[8:13] $rose(REFRESH_ACTIVE))
        else $error("first refresh");
    cover property ($rose(REFRESH_WAIT_STATE));
    cover property ($fell(BUS_GRANTED) ##[1:90] $rose(REFRESH_ACTIVE));
    cover property ($fell(SLEEP_MODE) ##[1:20] $rose(REFRESH_ACTIVE));
endmodule // drc_props

// ===== bench/drc_dram.sv
// DRAM on the refresh bus: counts refreshes and address skips.
// Assumes the controller clock; slow adds random CPU waits.
module drc_dram (
    // Bus side
    input wire clk, slow, act,
    input wire [7:0] addr,
    // To CPU and bench
    output logic wait_o,
    output int refs, skips
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last_reg;
    logic act_reg = '0;
    initial wait_o = '0;
    always @(posedge clk) begin
        act_reg <= act;
        wait_o <= slow && $urandom % 3 == 0;
        if (act && !act_reg) begin
            skips <= skips + int'(refs > 0 && addr !== last_reg + 8'h01);
            last_reg <= addr;
            refs <= refs + 1;
        end
    end
endmodule // drc_dram

// ===== bench/drc_tb.sv
// Bench for the refresh controller with a DRAM model.
// Assumes checker and DRAM model compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = '0, rst = '1, psel = '0, pen = '0, pwr = '0, bg = '0, slp = '0, mce = '0;
    logic slow = '0, pready, pslverr, ra, rws, ws, er;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic [7:0] raddr, v;
    int error_cnt, tests_run, cyc, len, lst, refs, skips, n, p;
    int rises[$];
    always #50 clk = ~clk;
    drc_refresh drc_refresh_inst (.CLOCK(clk), .SRST(rst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .BUS_GRANTED(bg), .SLEEP_MODE(slp), .WAIT_STATE(ws),
        .MCYCLE_END(mce), .REFRESH_ACTIVE(ra), .REFRESH_WAIT_STATE(rws), .REFRESH_ADDR(raddr));
    drc_dram drc_dram_inst (.clk(clk), .slow(slow), .act(ra), .addr(raddr), .wait_o(ws),
        .refs(refs), .skips(skips));
    always @(posedge clk) begin
        cyc++;
        if (ra === 1'b1 && len++ == 0)
            rises.push_back(cyc);
        if (ra !== 1'b1 && len > 0)
            lst = len;
        if (ra !== 1'b1)
            len = 0;
    end
    task automatic chk(input bit ok, input string m);
        tests_run++;
        if (!ok) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic summarize();
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Starts one edge late so a release and a new setup never share a step
    task automatic apb(input bit w, input [7:0] a, input [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= 32'(a);
        pwdata <= 32'(d);
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        chk(n < 20, "no ready");
        if (n >= 20)
            summarize();
    endtask
    task automatic settle(input int want);
        for (n = 0; n < 900 && rises.size() < want; n++)
            @(posedge clk);
        chk(n < 900, "no refresh");
        if (n >= 900)
            summarize();
    endtask
    initial begin
        void'($urandom(32'h99d2));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        apb(0, 8'hD8, 8'h00);
        chk(rd[7:0] === 8'hC0, "ctrl reset");
        settle(3);
        chk(rises[2] - rises[1] == 10 && lst == 3, "reset timing");
        for (int s = 0; s < 4; s++) begin
            v = 8'($urandom) | 8'h80;
            v[1:0] = 2'(s);
            apb(1, 8'hD8, v);
            apb(0, 8'hD8, 8'h00);
            chk(rd[7:0] === (v & 8'hC3), "readback");
            rises.delete();
            settle(3);
            repeat (4) @(posedge clk);
            chk(rises[2] - rises[1] == 10 << s && lst == 2 + v[6], "interval");
        end
        apb(1, 8'hD8, 8'h40);
        repeat (2) @(posedge clk);
        rises.delete();
        repeat (200) @(posedge clk);
        chk(rises.size() == 0, "refresh off");
        apb(1, 8'hD8, 8'h80);
        settle(2);
        p = rises[1];
        bg <= 1'b1;
        rises.delete();
        repeat (95) @(posedge clk);
        chk(rises.size() == 0, "refresh in grant");
        bg <= 1'b0;
        settle(2);
        chk((rises[0] - p) % 10 == 0 && rises[1] - rises[0] == 10, "grant phase");
        p = rises[1];
        slp <= 1'b1;
        rises.delete();
        repeat (50) @(posedge clk);
        slp <= 1'b0;
        repeat (2) @(posedge clk);
        chk(rises.size() == 0, "sleep early");
        mce <= 1'b1;
        @(posedge clk);
        mce <= 1'b0;
        repeat (4) @(posedge clk);
        chk(rises.size() == 1, "sleep refresh");
        settle(2);
        chk((rises[1] - p) % 10 == 0, "sleep phase");
        apb(0, 8'h40, 8'h00);
        chk(er === 1'b1 && rd === 32'h0000_0000, "unmapped");
        p = refs;
        slow <= 1'b1;
        repeat (300) @(posedge clk);
        slow <= 1'b0;
        chk(skips == 0 && refs - p > 20, "addresses");
        apb(1, 8'hD8, 8'h00);
        repeat (4) @(posedge clk);
        apb(0, 8'h3C, 8'h00);
        chk(rd === {24'h00_0000, refs[7:0]}, "address count");
        summarize();
    end
endmodule // tb
bind drc_refresh drc_props #(.RADDR_W(RADDR_W)) drc_props_inst (.CLOCK(CLOCK), .SRST(SRST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .BUS_GRANTED(BUS_GRANTED),
    .SLEEP_MODE(SLEEP_MODE), .WAIT_STATE(WAIT_STATE), .REFRESH_ACTIVE(REFRESH_ACTIVE),
    .REFRESH_WAIT_STATE(REFRESH_WAIT_STATE), .REFRESH_ADDR(REFRESH_ADDR));
